// ---- hdl/fcs_pkg.sv ----
// shared constants and types of the flash command sequencer
package fcs_pkg;
  // software register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_CFG    = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA  = 8'h14;

  // status field positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_RB   = 3;

  // reset values
  localparam logic        CFG_WORD_RST = 1'b1;
  localparam logic [17:0] ADDR_RST     = 18'h00000;
  localparam logic [15:0] DATA_RST     = 16'h0000;

  // operations written to the control register
  localparam logic [3:0] OP_READ   = 4'h0;
  localparam logic [3:0] OP_RESET  = 4'h1;
  localparam logic [3:0] OP_IDENT  = 4'h2;
  localparam logic [3:0] OP_PROG   = 4'h3;
  localparam logic [3:0] OP_CHIP   = 4'h4;
  localparam logic [3:0] OP_SECT   = 4'h5;
  localparam logic [3:0] OP_SADD   = 4'h6;
  localparam logic [3:0] OP_SUSP   = 4'h7;
  localparam logic [3:0] OP_RESUME = 4'h8;
  localparam logic [3:0] OP_LAST   = 4'h8;

  // command bytes and unlock addresses
  localparam logic [15:0] CD_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] CD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CD_PROG    = 16'h00a0;
  localparam logic [15:0] CD_IDENT   = 16'h0090;
  localparam logic [15:0] CD_ERASE   = 16'h0080;
  localparam logic [15:0] CD_CHIP    = 16'h0010;
  localparam logic [15:0] CD_SECT    = 16'h0030;
  localparam logic [15:0] CD_RESET   = 16'h00f0;
  localparam logic [15:0] CD_SUSP    = 16'h00b0;
  localparam logic [15:0] CD_RESUME  = 16'h0030;
  localparam logic [17:0] UA1_WORD   = 18'h00555;
  localparam logic [17:0] UA2_WORD   = 18'h002aa;
  localparam logic [17:0] UA1_BYTE   = 18'h00aaa;
  localparam logic [17:0] UA2_BYTE   = 18'h00555;
  localparam logic [17:0] ADDR_ANY   = 18'h00000;

  // pin timing
  localparam int CLK_NS     = 50;
  localparam int WE_LOW_NS  = 35;
  localparam int RD_ACC_NS  = 120;
  localparam int WE_CYC     = ((WE_LOW_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC     = ((RD_ACC_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : (RD_ACC_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {CYC_IDLE, CYC_SETUP, CYC_STROBE, CYC_HOLD} fcs_cyc_e;
  typedef enum logic [2:0] {SQ_IDLE, SQ_SEQ, SQ_POLL, SQ_RECHK, SQ_FINAL, SQ_ABORT} fcs_seq_e;
endpackage

// ---- hdl/fcs_bus_cycle.sv ----
// one flash bus cycle: write or read with strobe timing
`timescale 1ns/1ns
module fcs_bus_cycle (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic        req_rd,
  input  wire logic [17:0] req_addr,
  input  wire logic [15:0] req_data,
  output logic             ack,
  output logic [15:0]      rd_data,
  output logic             ce_n,
  output logic             we_n,
  output logic             oe_n,
  output logic [17:0]      addr,
  output logic [15:0]      dq_o,
  output logic             dq_oe,
  input  wire logic [15:0] dq_i
);
  typedef struct packed {
    fcs_pkg::fcs_cyc_e st;
    logic [2:0]        cnt;
    logic              rd;
    logic              ack;
    logic [15:0]       rdata;
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic [17:0]       addr;
    logic [15:0]       dq_o;
    logic              dq_oe;
  } fcs_cyc_s;

  fcs_cyc_s s_r;
  fcs_cyc_s s_nxt;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.ack = 1'b0;
    case (s_r.st)
      fcs_pkg::CYC_IDLE: begin
        // ack still high means the requester has not yet moved on
        if (req && !s_r.ack) begin
          s_nxt.addr  = req_addr;
          s_nxt.dq_o  = req_data;
          s_nxt.dq_oe = !req_rd;
          s_nxt.rd    = req_rd;
          s_nxt.st    = fcs_pkg::CYC_SETUP;
        end
      end
      fcs_pkg::CYC_SETUP: begin
        // address settles a full cycle before both strobes fall together
        s_nxt.ce_n = 1'b0;
        s_nxt.oe_n = !s_r.rd;
        s_nxt.we_n = s_r.rd;
        s_nxt.cnt  = s_r.rd ? 3'(fcs_pkg::RD_CYC - 1) : 3'(fcs_pkg::WE_CYC - 1);
        s_nxt.st   = fcs_pkg::CYC_STROBE;
      end
      fcs_pkg::CYC_STROBE: begin
        if (s_r.cnt == 3'h0) begin
          if (s_r.rd) begin
            s_nxt.rdata = dq_i;
          end
          s_nxt.ce_n = 1'b1;
          s_nxt.we_n = 1'b1;
          s_nxt.oe_n = 1'b1;
          s_nxt.st   = fcs_pkg::CYC_HOLD;
        end else begin
          s_nxt.cnt = s_r.cnt - 3'h1;
        end
      end
      fcs_pkg::CYC_HOLD: begin
        // data held one cycle past the strobe rise
        s_nxt.dq_oe = 1'b0;
        s_nxt.ack   = 1'b1;
        s_nxt.st    = fcs_pkg::CYC_IDLE;
      end
      default: s_nxt.st = fcs_pkg::CYC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: fcs_pkg::CYC_IDLE, cnt: 3'h0, rd: 1'b0, ack: 1'b0, rdata: 16'h0000, ce_n: 1'b1,
               we_n: 1'b1, oe_n: 1'b1, addr: 18'h00000, dq_o: 16'h0000, dq_oe: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ack     = s_r.ack;
  assign rd_data = s_r.rdata;
  assign ce_n    = s_r.ce_n;
  assign we_n    = s_r.we_n;
  assign oe_n    = s_r.oe_n;
  assign addr    = s_r.addr;
  assign dq_o    = s_r.dq_o;
  assign dq_oe   = s_r.dq_oe;
endmodule // fcs_bus_cycle

// ---- hdl/fcs_ctrl.sv ----
// flash command sequencer: apb registers, command sequences and status polling
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module fcs_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             ce_n,
  output logic             we_n,
  output logic             oe_n,
  output logic [17:0]      flash_addr,
  output logic [15:0]      dq_o,
  output logic             dq_oe,
  input  wire logic [15:0] dq_i,
  input  wire logic        ready_busy_n_output,
  output logic             word_mode
);
  typedef struct packed {
    fcs_pkg::fcs_seq_e st;
    logic [3:0]        op;
    logic [2:0]        idx;
    logic              req;
    logic              busy;
    logic              done;
    logic              fail;
    logic [15:0]       rdata;
    logic [17:0]       addr;
    logic [15:0]       data;
    logic              word;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } fcs_ctrl_s;

  fcs_ctrl_s s_r;
  fcs_ctrl_s s_nxt;

  logic        eng_ack;
  logic [15:0] eng_rd;
  logic        stp_rd;
  logic [17:0] stp_addr;
  logic [15:0] stp_data;
  logic [17:0] ua1;
  logic [17:0] ua2;
  logic [2:0]  last_idx;
  logic        poll_op;
  logic        dq7_exp;
  logic        match;
  logic        wr_acc;
  logic        rd_set;

  assign ua1      = s_r.word ? fcs_pkg::UA1_WORD : fcs_pkg::UA1_BYTE;
  assign ua2      = s_r.word ? fcs_pkg::UA2_WORD : fcs_pkg::UA2_BYTE;
  assign poll_op  = (s_r.op == fcs_pkg::OP_PROG) || (s_r.op == fcs_pkg::OP_CHIP) || (s_r.op == fcs_pkg::OP_SECT);
  // erase finishes with all ones, program with the written bit
  assign dq7_exp  = (s_r.op == fcs_pkg::OP_PROG) ? s_r.data[7] : 1'b1;
  assign match    = eng_rd[7] == dq7_exp;
  assign wr_acc   = psel && penable && s_r.pready && pwrite;
  assign rd_set   = psel && !penable;

  always_comb begin
    case (s_r.op)
      fcs_pkg::OP_PROG, fcs_pkg::OP_IDENT: last_idx = 3'h3;
      fcs_pkg::OP_CHIP, fcs_pkg::OP_SECT:  last_idx = 3'h5;
      default:                             last_idx = 3'h0;
    endcase
  end

  // bus cycle for the current step; command bytes keep the upper byte at zero
  always_comb begin
    stp_rd   = 1'b0;
    stp_addr = fcs_pkg::ADDR_ANY;
    stp_data = fcs_pkg::CD_RESET;
    case (s_r.st)
      fcs_pkg::SQ_POLL, fcs_pkg::SQ_RECHK, fcs_pkg::SQ_FINAL: begin
        stp_rd   = 1'b1;
        stp_addr = s_r.addr;
      end
      fcs_pkg::SQ_ABORT: begin
        stp_data = fcs_pkg::CD_RESET;
      end
      default: begin
        case (s_r.op)
          fcs_pkg::OP_READ: begin
            stp_rd   = 1'b1;
            stp_addr = s_r.addr;
          end
          fcs_pkg::OP_RESET:  stp_data = fcs_pkg::CD_RESET;
          fcs_pkg::OP_SUSP:   stp_data = fcs_pkg::CD_SUSP;
          fcs_pkg::OP_RESUME: stp_data = fcs_pkg::CD_RESUME;
          fcs_pkg::OP_SADD: begin
            stp_addr = s_r.addr;
            stp_data = fcs_pkg::CD_SECT;
          end
          default: begin
            case (s_r.idx)
              3'h0: begin
                stp_addr = ua1;
                stp_data = fcs_pkg::CD_UNLOCK1;
              end
              3'h1: begin
                stp_addr = ua2;
                stp_data = fcs_pkg::CD_UNLOCK2;
              end
              3'h2: begin
                stp_addr = ua1;
                stp_data = (s_r.op == fcs_pkg::OP_PROG) ? fcs_pkg::CD_PROG :
                           (s_r.op == fcs_pkg::OP_IDENT) ? fcs_pkg::CD_IDENT : fcs_pkg::CD_ERASE;
              end
              3'h3: begin
                stp_addr = (s_r.op == fcs_pkg::OP_PROG || s_r.op == fcs_pkg::OP_IDENT) ? s_r.addr : ua1;
                stp_data = (s_r.op == fcs_pkg::OP_PROG) ? s_r.data : fcs_pkg::CD_UNLOCK1;
                stp_rd   = s_r.op == fcs_pkg::OP_IDENT;
              end
              3'h4: begin
                stp_addr = ua2;
                stp_data = fcs_pkg::CD_UNLOCK2;
              end
              default: begin
                stp_addr = (s_r.op == fcs_pkg::OP_SECT) ? s_r.addr : ua1;
                stp_data = (s_r.op == fcs_pkg::OP_SECT) ? fcs_pkg::CD_SECT : fcs_pkg::CD_CHIP;
              end
            endcase
          end
        endcase
      end
    endcase
  end

  always_comb begin
    s_nxt         = s_r;
    s_nxt.pready  = rd_set;
    s_nxt.pslverr = 1'b0;
    // read data and error are prepared in the setup phase so they leave flops
    if (rd_set) begin
      s_nxt.prdata = 32'h00000000;
      case (paddr)
        fcs_pkg::REG_CTRL:   s_nxt.prdata[3:0] = s_r.op;
        fcs_pkg::REG_ADDR:   s_nxt.prdata[17:0] = s_r.addr;
        fcs_pkg::REG_DATA:   s_nxt.prdata[15:0] = s_r.data;
        fcs_pkg::REG_CFG:    s_nxt.prdata[0] = s_r.word;
        fcs_pkg::REG_STATUS: begin
          s_nxt.prdata[fcs_pkg::ST_BUSY] = s_r.busy;
          s_nxt.prdata[fcs_pkg::ST_DONE] = s_r.done;
          s_nxt.prdata[fcs_pkg::ST_FAIL] = s_r.fail;
          s_nxt.prdata[fcs_pkg::ST_RB]   = ready_busy_n_output;
        end
        fcs_pkg::REG_RDATA:  s_nxt.prdata[15:0] = s_r.rdata;
        default:             s_nxt.pslverr = 1'b1;
      endcase
    end
    // parameters cannot change under a running sequence
    if (wr_acc && !s_r.busy) begin
      case (paddr)
        fcs_pkg::REG_ADDR: s_nxt.addr = pwdata[17:0];
        fcs_pkg::REG_DATA: s_nxt.data = pwdata[15:0];
        fcs_pkg::REG_CFG:  s_nxt.word = pwdata[0];
        fcs_pkg::REG_CTRL: begin
          if (pwdata[3:0] <= fcs_pkg::OP_LAST) begin
            s_nxt.op   = pwdata[3:0];
            s_nxt.idx  = 3'h0;
            s_nxt.req  = 1'b1;
            s_nxt.busy = 1'b1;
            s_nxt.done = 1'b0;
            s_nxt.fail = 1'b0;
            s_nxt.st   = fcs_pkg::SQ_SEQ;
          end
        end
        default: ;
      endcase
    end
    case (s_r.st)
      fcs_pkg::SQ_IDLE: ;
      fcs_pkg::SQ_SEQ: begin
        if (eng_ack) begin
          if (s_r.idx == last_idx) begin
            if (poll_op) begin
              s_nxt.st = fcs_pkg::SQ_POLL;
            end else begin
              s_nxt.rdata = eng_rd;
              s_nxt.req   = 1'b0;
              s_nxt.busy  = 1'b0;
              s_nxt.done  = 1'b1;
              s_nxt.st    = fcs_pkg::SQ_IDLE;
            end
          end else begin
            s_nxt.idx = s_r.idx + 3'h1;
          end
        end
      end
      fcs_pkg::SQ_POLL: begin
        if (eng_ack) begin
          if (match) begin
            s_nxt.st = fcs_pkg::SQ_FINAL;
          end else if (eng_rd[5]) begin
            s_nxt.st = fcs_pkg::SQ_RECHK;
          end
        end
      end
      fcs_pkg::SQ_RECHK: begin
        if (eng_ack) begin
          s_nxt.st = match ? fcs_pkg::SQ_FINAL : fcs_pkg::SQ_ABORT;
        end
      end
      fcs_pkg::SQ_FINAL: begin
        // status bit may flip ahead of the others, so take this fresh read
        if (eng_ack) begin
          s_nxt.rdata = eng_rd;
          s_nxt.req   = 1'b0;
          s_nxt.busy  = 1'b0;
          s_nxt.done  = 1'b1;
          s_nxt.st    = fcs_pkg::SQ_IDLE;
        end
      end
      fcs_pkg::SQ_ABORT: begin
        if (eng_ack) begin
          s_nxt.fail = 1'b1;
          s_nxt.req  = 1'b0;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.st   = fcs_pkg::SQ_IDLE;
        end
      end
      default: s_nxt.st = fcs_pkg::SQ_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: fcs_pkg::SQ_IDLE, op: fcs_pkg::OP_READ, idx: 3'h0, req: 1'b0, busy: 1'b0, done: 1'b0,
               fail: 1'b0, rdata: 16'h0000, addr: fcs_pkg::ADDR_RST, data: fcs_pkg::DATA_RST,
               word: fcs_pkg::CFG_WORD_RST, pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000};
    end else begin
      s_r <= s_nxt;
    end
  end

  fcs_bus_cycle u_cyc (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .req      (s_r.req),
    .req_rd   (stp_rd),
    .req_addr (stp_addr),
    .req_data (stp_data),
    .ack      (eng_ack),
    .rd_data  (eng_rd),
    .ce_n     (ce_n),
    .we_n     (we_n),
    .oe_n     (oe_n),
    .addr     (flash_addr),
    .dq_o     (dq_o),
    .dq_oe    (dq_oe),
    .dq_i     (dq_i)
  );

  assign prdata    = s_r.prdata;
  assign pready    = s_r.pready;
  assign pslverr   = s_r.pslverr;
  assign word_mode = s_r.word;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  abort_writes_f0_a: assert property (s_r.st == fcs_pkg::SQ_ABORT && s_r.req |-> !stp_rd && stp_data == 16'h00f0)
    else $error("abort cycle is not a reset write");
  prog_third_a: assert property (s_r.st == fcs_pkg::SQ_SEQ && s_r.op == fcs_pkg::OP_PROG && s_r.idx == 3'h2
                                 |-> stp_data == 16'h00a0 && stp_addr == ua1 && !stp_rd)
    else $error("program setup byte wrong");
  first_unlock_a: assert property (s_r.st == fcs_pkg::SQ_SEQ && last_idx != 3'h0 && s_r.idx == 3'h0
                                   |-> stp_data == 16'h00aa && stp_addr == ua1)
    else $error("first unlock cycle wrong");
  erase_sixth_a: assert property (s_r.st == fcs_pkg::SQ_SEQ && s_r.op == fcs_pkg::OP_SECT && s_r.idx == 3'h5
                                  |-> stp_data == 16'h0030 && stp_addr == s_r.addr)
    else $error("sector erase last cycle wrong");
  writes_only_a: assert property (s_r.st == fcs_pkg::SQ_SEQ && s_r.idx != 3'h3 && s_r.op != fcs_pkg::OP_READ
                                  |-> !stp_rd)
    else $error("command cycle issued as read");
  ident_read_a: assert property (s_r.st == fcs_pkg::SQ_SEQ && s_r.op == fcs_pkg::OP_IDENT && s_r.idx == 3'h3
                                 |-> stp_rd && $past(s_r.idx) != 3'h0)
    else $error("identification fourth cycle not a read");
  poll_addr_a: assert property (s_r.st == fcs_pkg::SQ_POLL |-> stp_rd && stp_addr == s_r.addr)
    else $error("poll read at wrong address");
  erase_done_a: assert property (s_r.st == fcs_pkg::SQ_POLL && eng_ack && s_r.op != fcs_pkg::OP_PROG && eng_rd[7]
                                 |=> s_r.st == fcs_pkg::SQ_FINAL ##1 s_r.busy)
    else $error("erase completion not followed");
  final_read_a: assert property ($rose(s_r.done) && poll_op && !s_r.fail |-> $past(s_r.st) == fcs_pkg::SQ_FINAL)
    else $error("data taken without trailing read");
  recheck_a: assert property (s_r.st == fcs_pkg::SQ_POLL && eng_ack && !match && eng_rd[5]
                              |=> s_r.st == fcs_pkg::SQ_RECHK)
    else $error("timing-limit flag not rechecked");

  prog_ok_c:   cover property (s_r.st == fcs_pkg::SQ_FINAL && eng_ack && s_r.op == fcs_pkg::OP_PROG);
  fail_c:      cover property (s_r.st == fcs_pkg::SQ_ABORT && eng_ack);
  ident_c:     cover property (s_r.op == fcs_pkg::OP_IDENT && $rose(s_r.done));
  sect_erase_c: cover property (s_r.op == fcs_pkg::OP_SECT && $rose(s_r.done));
endmodule // fcs_ctrl

// ---- test/fcs_flash_model.sv ----
// behavioural flash device driven by the sequencer's strobes
`timescale 1ns/1ns
module fcs_flash_model #(
  parameter logic [15:0] MAKER_ID = 16'h005a, // arbitrary value
  parameter logic [15:0] PART_ID  = 16'h1234, // arbitrary value
  parameter logic [5:0]  PROT_SECT = 6'h3e    // the one sector that refuses program and erase
) (
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [17:0] addr,
  input  wire logic [15:0] dq,
  input  wire logic        word_mode,
  input  wire logic [3:0]  poll_len,
  input  wire logic        fail_en,
  output logic [15:0]      q,
  output logic             q_oe,
  output logic             rb_n
);
  logic [15:0] mem [int];
  int          ks[$];
  logic [17:0] la, prog_loc;
  logic [15:0] prog_val;
  logic [2:0]  seq;
  logic [1:0]  op;
  logic        ident, susp, chip;
  logic [3:0]  left;
  logic [5:0]  sect;
  logic [10:0] u1, u2;
  initial begin
    q = '0; seq = '0; op = '0; ident = 0; susp = 0; chip = 0; left = '0;
  end
  assign u1 = word_mode ? 11'h555 : 11'haaa;
  assign u2 = word_mode ? 11'h2aa : 11'h555;
  assign q_oe = !ce_n && !oe_n;
  assign rb_n = !(op != 2'd0 && !susp);
  always @(negedge (ce_n | we_n)) la = addr;
  always @(posedge (ce_n | we_n)) begin
    if (op == 2'd2 && !chip && !susp && dq[7:0] == 8'hb0) susp = 1;
    else if (susp && dq[7:0] == 8'h30) susp = 0;
    else if (dq[7:0] == 8'hf0 && (op == 2'd0 || fail_en)) begin
      seq = '0; ident = 0; op = '0;
    end else if (op != 2'd0) ;
    else case (seq)
      3'd0: seq = (la[10:0] == u1 && dq[7:0] == 8'haa) ? 3'd1 : 3'd0;
      3'd1: seq = (la[10:0] == u2 && dq[7:0] == 8'h55) ? 3'd2 : 3'd0;
      3'd2: begin
        seq = '0;
        if (la[10:0] == u1 && dq[7:0] == 8'ha0) seq = 3'd3;
        if (la[10:0] == u1 && dq[7:0] == 8'h80) seq = 3'd4;
        if (la[10:0] == u1 && dq[7:0] == 8'h90) ident = 1;
      end
      3'd3: begin
        prog_loc = la; prog_val = dq; op = 2'd1; left = poll_len; seq = '0;
      end
      3'd4: seq = (la[10:0] == u1 && dq[7:0] == 8'haa) ? 3'd5 : 3'd0;
      3'd5: seq = (la[10:0] == u2 && dq[7:0] == 8'h55) ? 3'd6 : 3'd0;
      default: begin
        chip = la[10:0] == u1 && dq[7:0] == 8'h10;
        if (chip || dq[7:0] == 8'h30) begin
          op = 2'd2; sect = la[17:12]; left = poll_len;
        end
        seq = '0;
      end
    endcase
  end
  always @(negedge (ce_n | oe_n)) begin
    if (op == 2'd1) begin
      q = {8'h00, ~prog_val[7], 1'b0, fail_en, 5'h00};
      if (left == 4'd0 && !fail_en) begin
        // a protected target shows status for a while, then array data, unchanged
        if (prog_loc[17:12] != PROT_SECT) mem[prog_loc] = prog_val;
        op = '0;
        q = mem.exists(prog_loc) ? mem[prog_loc] : 16'hffff;
      end else left = left - 4'd1;
    end else if (op == 2'd2) begin
      q = susp ? 16'h0080 : 16'h0000;
      if (!susp && left == 4'd0) begin
        ks.delete();
        foreach (mem[k]) ks.push_back(k);
        foreach (ks[i]) if ((chip || ks[i][17:12] == sect) && ks[i][17:12] != PROT_SECT) mem.delete(ks[i]);
        op = '0; q = 16'h00ff;
      end else if (!susp) left = left - 4'd1;
    end else if (ident && addr[7:0] == 8'h00) q = MAKER_ID;
    else if (ident && addr[7:0] == (word_mode ? 8'h01 : 8'h02)) q = PART_ID;
    else if (ident && addr[7:0] == (word_mode ? 8'h02 : 8'h04)) q = (addr[17:12] == PROT_SECT) ? 16'h0001 : 16'h0000;
    else q = mem.exists(addr) ? mem[addr] : 16'hffff;
  end
endmodule // fcs_flash_model

// ---- test/test_flash_command_and_status_logic.sv ----
// self-checking bench: apb sequences against the flash model
`timescale 1ns/1ns
module test_flash_command_and_status_logic;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, slv;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        ce_n, we_n, oe_n, dq_oe, word_mode, q_oe, rb_n, fail_en, rb_low;
  logic [17:0] flash_addr;
  logic [15:0] dq_o, dq_i, q;
  logic [3:0]  poll_len;
  int          err_count, checks_done, n, i;
  logic [17:0] loc_t [2] = '{18'h01234, 18'h3f0a6};
  logic [15:0] val_t [2] = '{16'h5a3c, 16'h00c3};
  always #25 sys_clk = ~sys_clk;
  // released data lines show the inverse of the last value rather than a fixed level
  assign dq_i = dq_oe ? dq_o : (q_oe ? q : ~q);
  fcs_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .flash_addr(flash_addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
    .ready_busy_n_output(rb_n), .word_mode(word_mode));
  fcs_flash_model mdl (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(flash_addr), .dq(dq_i),
    .word_mode(word_mode), .poll_len(poll_len), .fail_en(fail_en), .q(q), .q_oe(q_oe), .rb_n(rb_n));
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    slv = pslverr;
    psel <= 0; penable <= 0;
    if (k >= 20) begin
      err_count++;
      test_done();
    end
  endtask
  task automatic run(input logic [3:0] o, input logic [17:0] a, input logic [15:0] d);
    apb(1, fcs_pkg::REG_ADDR, {14'h0, a});
    apb(1, fcs_pkg::REG_DATA, {16'h0, d});
    apb(1, fcs_pkg::REG_CTRL, {28'h0, o});
    rb_low = 0;
    for (n = 0; n < 400; n++) begin
      apb(0, fcs_pkg::REG_STATUS, 32'h0);
      if (r[3] === 1'b0) rb_low = 1;
      if (r[0] === 1'b0) break;
    end
    if (n == 400) begin
      err_count++;
      test_done();
    end
  endtask
  task automatic rd(input string nm, input logic [17:0] a, input logic [15:0] e);
    run(fcs_pkg::OP_READ, a, 16'h0);
    apb(0, fcs_pkg::REG_RDATA, 32'h0);
    chk(nm, r, {16'h0, e});
  endtask
  initial begin
    sys_clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    poll_len = '0; fail_en = 0; err_count = 0; checks_done = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1;
    apb(0, fcs_pkg::REG_CFG, 32'h0);
    chk("cfg", r, 32'h1);
    apb(0, 8'h18, 32'h0);
    chk("unmapped", {31'h0, slv}, 32'h1);
    rd("blank", 18'h01234, 16'hffff);
    for (i = 0; i < 2; i++) begin
      poll_len <= 4'(i * 3);
      run(fcs_pkg::OP_PROG, loc_t[i], val_t[i]);
      chk("prog status", r & 32'h7, 32'h2);
      apb(0, fcs_pkg::REG_RDATA, 32'h0);
      chk("prog data", r, {16'h0, val_t[i]});
      rd("readback", loc_t[i], val_t[i]);
    end
    poll_len <= 4'hf;
    run(fcs_pkg::OP_SECT, 18'h01000, 16'h0);
    chk("busy pin", {31'h0, rb_low}, 32'h1);
    rd("erased", 18'h01234, 16'hffff);
    rd("kept", 18'h3f0a6, 16'h00c3);
    run(fcs_pkg::OP_IDENT, 18'h00000, 16'h0);
    apb(0, fcs_pkg::REG_RDATA, 32'h0);
    chk("maker", r, 32'h005a);
    run(fcs_pkg::OP_IDENT, 18'h00001, 16'h0);
    apb(0, fcs_pkg::REG_RDATA, 32'h0);
    chk("part", r, 32'h1234);
    run(fcs_pkg::OP_IDENT, 18'h01002, 16'h0);
    apb(0, fcs_pkg::REG_RDATA, 32'h0);
    chk("protect", r, 32'h0);
    run(fcs_pkg::OP_IDENT, 18'h3e002, 16'h0);
    apb(0, fcs_pkg::REG_RDATA, 32'h0);
    chk("protected id", r, 32'h1);
    run(fcs_pkg::OP_RESET, 18'h0, 16'h0);
    rd("after reset", 18'h00000, 16'hffff);
    run(fcs_pkg::OP_PROG, 18'h3e010, 16'h0080);
    chk("prot status", r & 32'h7, 32'h2);
    rd("prot kept", 18'h3e010, 16'hffff);
    run(fcs_pkg::OP_SUSP, 18'h0, 16'h0);
    chk("susp status", r & 32'h7, 32'h2);
    run(fcs_pkg::OP_RESUME, 18'h0, 16'h0);
    chk("resume status", r & 32'h7, 32'h2);
    poll_len <= 4'h2;
    run(fcs_pkg::OP_CHIP, 18'h0, 16'h0);
    rd("chip erased", 18'h3f0a6, 16'hffff);
    apb(1, fcs_pkg::REG_CFG, 32'h0);
    // the mode flop takes the write at the access edge, so look one edge later
    @(posedge sys_clk);
    chk("byte mode", {31'h0, word_mode}, 32'h0);
    run(fcs_pkg::OP_PROG, 18'h00100, 16'h0077);
    rd("byte prog", 18'h00100, 16'h0077);
    apb(1, fcs_pkg::REG_CFG, 32'h1);
    fail_en <= 1;
    run(fcs_pkg::OP_PROG, 18'h00200, 16'h0011);
    chk("fail status", r & 32'h7, 32'h6);
    fail_en <= 0;
    rd("not programmed", 18'h00200, 16'hffff);
    test_done();
  end
endmodule // test_flash_command_and_status_logic
